// ### logic/pbm_burst.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module pbm_burst #(
    parameter int FIFO_W = pbm_pkg::DATA_W,
    parameter int FIFO_D = pbm_pkg::FIFO_DEPTH,
    parameter int PDX_N  = pbm_pkg::PDX_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire pbm_pkg::pbm_cfg_t         cfg,
    input  wire pbm_pkg::pbm_pins_t        pins,
    output logic                           wait_o,
    output logic                           wait_oe,
    output logic [pbm_pkg::DATA_W-1:0]     dq_out,
    output logic                           dq_oe,
    input  wire logic [pbm_pkg::DATA_W-1:0] rd_data,
    output logic                           rd_take,
    output logic                           wr_valid,
    input  wire logic                      wr_ready,
    output logic [pbm_pkg::DATA_W-1:0]     wr_data,
    input  wire logic                      pd_enter,
    output logic                           pd_active,
    output logic                           ready
);
    import pbm_pkg::*;
    initial begin
        if (PDX_N < 1 || PDX_N >= (1 << PDX_CW)) $error("pbm_burst power-up count out of range");
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; burst clock is sampled, not used as a clock
    pbm_pins_t s1_q;
    pbm_pins_t s2_q;
    logic      bclk_prev_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_q <= '1;
            s2_q <= '1;
            bclk_prev_q <= 1'b1; // Matches reset of s2; no false edge
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            bclk_prev_q <= s2_q.burst_clk;
        end
    end
    wire bclk_rise = s2_q.burst_clk && !bclk_prev_q;
    wire sel       = !s2_q.chip_sel_n;

    //////////////////////////////////////////////////////////////////////////
    // Burst state machine
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LAT  = 5'b00010,
        ST_DATA = 5'b00100,
        ST_ROWW = 5'b01000,
        ST_PD   = 5'b10000
    } pbm_st_t;

    pbm_st_t          st_q;
    pbm_st_t          st_d;
    logic             is_wr_q;
    logic [LC_W:0]    cnt_q;
    logic [ROW_W-1:0] col_q;
    logic [PDX_CW-1:0] pu_q;
    logic             busy_q;
    logic             ready_q;

    function automatic logic [LC_W:0] lat_cycles(input logic [LC_W-1:0] lc, input logic plus1);
        lat_cycles = {1'b0, lc} + (LC_W+1)'(plus1);
    endfunction

    // Read latency is LC+1 clocks, or LC at a row crossing without fixed_latency; write waits LC clocks
    wire [LC_W:0] start_lat = lat_cycles(cfg.latency_code_value, 1'b0);
    wire [LC_W:0] row_lat   = lat_cycles(cfg.latency_code_value,
                                         !is_wr_q && cfg.fixed_latency);
    wire          start     = sel && !s2_q.address_valid_n && bclk_rise;
    wire          row_end   = col_q == '1;
    wire          fifo_rdy;
    wire          word_ok   = bclk_rise && (is_wr_q ? fifo_rdy : 1'b1);

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (pd_enter && !sel) begin
                    st_d = ST_PD;
                end else if (start && ready_q) begin
                    st_d = ST_LAT;
                end
            end
            ST_LAT: begin
                if (bclk_rise && cnt_q <= (LC_W+1)'(1)) begin
                    st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (word_ok && row_end) begin
                    st_d = cfg.wrap_off ? ST_DATA : ST_ROWW;
                end
            end
            ST_ROWW: begin
                if (bclk_rise && cnt_q <= (LC_W+1)'(1)) begin
                    st_d = ST_DATA;
                end
            end
            ST_PD: begin
                if (sel) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (!sel && st_q != ST_PD && st_q != ST_IDLE) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            is_wr_q <= 1'b0;
            cnt_q   <= '0;
            col_q   <= '0;
        end else if (st_q == ST_IDLE && start) begin
            is_wr_q <= !s2_q.write_en_n;
            cnt_q   <= s2_q.write_en_n ? start_lat + (LC_W+1)'(1) : start_lat;
            col_q   <= '0;
        end else if (st_d == ST_ROWW && st_q == ST_DATA) begin
            cnt_q   <= row_lat;
            col_q   <= '0;
        end else if (bclk_rise && (st_q == ST_LAT || st_q == ST_ROWW)) begin
            cnt_q   <= cnt_q - (LC_W+1)'(1);
        end else if (st_q == ST_DATA && word_ok) begin
            col_q   <= col_q + ROW_W'(1);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Power-down exit timing
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pu_q    <= '0;
            ready_q <= 1'b1;
        end else if (st_q == ST_PD) begin
            pu_q    <= PDX_CW'(PDX_N);
            ready_q <= 1'b0;
        end else if (pu_q != '0) begin
            pu_q    <= pu_q - PDX_CW'(1);
        end else begin
            ready_q <= 1'b1;
        end
    end
    assign ready     = ready_q;
    assign pd_active = st_q == ST_PD;

    //////////////////////////////////////////////////////////////////////////
    // Wait output; wait_during_delay asserts for the whole latency count, otherwise only on its last count
    wire wait_core = (st_q == ST_LAT || st_q == ST_ROWW) &&
                     (cfg.wait_during_delay || cnt_q <= (LC_W+1)'(1));
    logic wait_q;
    logic [DATA_W-1:0] dq_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wait_q <= 1'b0;
            busy_q <= 1'b0;
            dq_q   <= '0;
        end else begin
            wait_q <= cfg.wait_active_high ? wait_core : !wait_core;
            busy_q <= sel;
            if (st_q == ST_DATA && !is_wr_q && bclk_rise) begin
                dq_q <= rd_data; // Held while clock is parked
            end
        end
    end
    assign wait_o  = wait_q;
    assign wait_oe = busy_q;
    assign dq_out  = dq_q;
    assign dq_oe   = sel && !is_wr_q && !s2_q.out_en_n && st_q == ST_DATA;
    assign rd_take = st_q == ST_DATA && !is_wr_q && bclk_rise;

    //////////////////////////////////////////////////////////////////////////
    // Write data buffer; full buffer stalls column advance
    pbm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (st_q == ST_DATA && is_wr_q && bclk_rise),
        .in_ready  (fifo_rdy),
        .in_data   (FIFO_W'(s2_q.dq_in)),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_data)
    );

    //////////////////////////////////////////////////////////////////////////
    wr_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == ST_IDLE && start && !s2_q.write_en_n && ready_q)
        |=> st_q == ST_LAT && cnt_q == start_lat)
        else $error("write latency load wrong");
    row_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == ST_DATA && st_d == ST_ROWW && !is_wr_q && cfg.fixed_latency)
        |=> cnt_q == {1'b0, cfg.latency_code_value} + 4'h1)
        else $error("row crossing wait wrong");
    wait_pol_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(st_q == ST_IDLE) |-> wait_o == !$past(cfg.wait_active_high))
        else $error("idle wait level wrong");
    dq_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == ST_DATA && !bclk_rise) |=> $stable(dq_out))
        else $error("suspend data changed");
    pd_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pu_q == PDX_CW'(1) && st_q != ST_PD) |=> ##1 ready)
        else $error("not ready after exit");

    //////////////////////////////////////////////////////////////////////////
    // Named steps of a burst; five of the checks below start from one of them
    sequence rd_begin_s;
        st_q == ST_IDLE && start && s2_q.write_en_n && ready_q;
    endsequence
    sequence refused_s;
        st_q == ST_IDLE && start && !ready_q;
    endsequence
    sequence lat_done_s;
        sel && bclk_rise && (st_q == ST_LAT || st_q == ST_ROWW) && cnt_q <= (LC_W+1)'(1);
    endsequence
    sequence rd_word_s;
        st_q == ST_DATA && !is_wr_q && bclk_rise;
    endsequence
    sequence wr_stall_s;
        st_q == ST_DATA && is_wr_q && bclk_rise && !fifo_rdy;
    endsequence

    // Read start loads one clock more than a write
    rd_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        rd_begin_s |=> st_q == ST_LAT && cnt_q == {1'b0, $past(cfg.latency_code_value)} + 4'h1)
        else $error("read latency load wrong");

    lat_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
        lat_done_s |=> st_q == ST_DATA)
        else $error("latency count overran");

    refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
        refused_s |=> st_q == ST_IDLE)
        else $error("start taken while not ready");

    pd_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == ST_PD |=> !ready)
        else $error("ready during power-down");

    rd_word_a: assert property (@(posedge clk) disable iff (!rst_b)
        rd_word_s |=> dq_out == $past(rd_data))
        else $error("read word not captured");

    dq_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        st_q != ST_DATA |-> !dq_oe)
        else $error("data driven outside burst");

    // Full buffer stalls the column, but wait does not show it to the host
    wr_stall_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr_stall_s |=> $stable(col_q))
        else $error("column moved on full buffer");

    // Wait level follows the state one clock later
    early_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(st_q == ST_LAT && cfg.wait_during_delay)
        |-> wait_o == $past(cfg.wait_active_high))
        else $error("early wait level wrong");

    data_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) && $past(st_q == ST_DATA) |-> wait_o == !$past(cfg.wait_active_high))
        else $error("wait held during data");

    // Select high always ends a burst; the host relies on it
    sel_end_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!sel && !pd_enter && st_q != ST_PD) |=> st_q == ST_IDLE)
        else $error("burst kept after select high");

    pd_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == ST_IDLE && pd_enter && !sel) |=> st_q == ST_PD)
        else $error("power-down request lost");
endmodule

// ### logic/pbm_pkg.sv
package pbm_pkg;
    localparam int DATA_W        = 16;
    localparam int LC_W          = 3;
    localparam int ROW_W         = 7;
    localparam int CLK_NS        = 100;
    localparam int PDX_US        = 150;
    localparam int PDX_CYC       = (PDX_US * 1000) / CLK_NS;
    localparam int PDX_CW        = 11;
    localparam int FIFO_DEPTH    = 8;
    localparam logic [LC_W-1:0] LC_RESET = 3'h3;

    typedef struct packed {
        logic [LC_W-1:0] latency_code_value;
        logic            fixed_latency;
        logic            wait_active_high;
        logic            wait_during_delay;
        logic            wrap_off;
    } pbm_cfg_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              address_valid_n;
        logic              out_en_n;
        logic              write_en_n;
        logic              burst_clk;
        logic [DATA_W-1:0] dq_in;
    } pbm_pins_t;
endpackage

// ### logic/pbm_fifo.sv
`timescale 1ns/10ps
module pbm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("pbm_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule

// ### verification/pbm_host.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Memory controller model driving the burst bus
module pbm_host
    import pbm_pkg::*;
(
    input  wire logic clk,
    input  wire logic wait_o,
    input  wire logic wait_act,
    output pbm_pins_t pins
);
    logic [DATA_W-1:0] sent[$];
    initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 16'h0000};
    // Half of the 800 ns burst period
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    // Burst clock parks low outside frames
    task automatic burst(input bit wr, input int n, output int wcnt);
        int got;
        logic [DATA_W-1:0] w;
        wcnt = 0;
        got = 0;
        w = 16'h0000;
        pins.chip_sel_n      <= 1'b0;
        pins.address_valid_n <= 1'b0;
        pins.write_en_n      <= !wr;
        pins.out_en_n        <= wr;
        half();
        pins.burst_clk <= 1'b1;
        for (int e = 0; e < 40 && got < n; e++) begin
            half();
            pins.burst_clk       <= 1'b0;
            pins.address_valid_n <= 1'b1;
            w = wr ? DATA_W'($urandom) : ~pins.dq_in;
            pins.dq_in <= w;
            half();
            pins.burst_clk <= 1'b1;
            // Word counted only when wait is idle
            if (wait_o === wait_act) begin
                wcnt++;
            end else begin
                got++;
                if (wr) begin
                    sent.push_back(w);
                end
            end
        end
        half();
        pins.burst_clk <= 1'b0;
        half();
        // Select high ends the burst, gives refresh chance
        pins.chip_sel_n <= 1'b1;
        pins.write_en_n <= 1'b1;
        pins.out_en_n   <= 1'b1;
        pins.dq_in      <= ~pins.dq_in;
        half();
    endtask
    // Select low pulse of 10 us leaves power-down
    task automatic pulse(input int n);
        pins.chip_sel_n <= 1'b0;
        repeat (n) @(posedge clk);
        pins.chip_sel_n <= 1'b1;
    endtask
endmodule

// ### verification/pbm_burst_bench.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module pbm_burst_bench;
    import pbm_pkg::*;
    // Short exit count keeps the run brief
    localparam int PDX = 20;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    pbm_cfg_t          cfg;
    pbm_pins_t         pins;
    logic              wait_o, wait_oe, dq_oe, rd_take, wr_valid, wr_ready;
    logic              pd_enter, pd_active, ready;
    logic [DATA_W-1:0] dq_out, rd_data, wr_data;
    int                miscompares = 0;
    int                n_tests = 0;
    int                wc, n_rd;
    logic [DATA_W-1:0] rd_exp[$];
    logic              rd_due = 1'b0;
    always #50 clk = ~clk;
    pbm_host host (.clk(clk), .wait_o(wait_o), .wait_act(cfg.wait_active_high), .pins(pins));
    pbm_burst #(.PDX_N(PDX)) dut (.clk(clk), .rst_b(rst_b), .cfg(cfg), .pins(pins),
        .wait_o(wait_o), .wait_oe(wait_oe), .dq_out(dq_out), .dq_oe(dq_oe),
        .rd_data(rd_data), .rd_take(rd_take), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .pd_enter(pd_enter), .pd_active(pd_active), .ready(ready));
    //////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        rd_data <= DATA_W'($urandom);
        if (rd_take === 1'b1) n_rd++;
        if (rd_due) begin
            check("dq_out", 32'(rd_exp.pop_front()), 32'(dq_out));
            check("dq_oe", 1, dq_oe);
        end
        rd_due <= rd_take === 1'b1;
        if (rd_take === 1'b1) rd_exp.push_back(rd_data);
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (host.sent.size() == 0) check("stray word", 1, 0);
            else check("wr_data", 32'(host.sent.pop_front()), 32'(wr_data));
        end
    end
    // Drain the stalled FIFO, bounded
    task automatic drain();
        wr_ready <= 1'b1;
        for (int i = 0; i < 100 && host.sent.size() > 0; i++) @(posedge clk);
        check("words left", 0, host.sent.size());
        @(posedge clk);
        check("wr_valid empty", 0, wr_valid);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    initial begin
        cfg = '0;
        rd_data = '0;
        wr_ready = 1'b0;
        pd_enter = 1'b0;
        void'($urandom(75));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        check("ready", 1, ready);
        check("pd_active", 0, pd_active);
        check("wait_oe", 0, wait_oe);
        check("dq_oe", 0, dq_oe);
        check("wr_valid", 0, wr_valid);
        $display("reset test done");
        // Codes 1 to 7 and both wait polarities; FIFO filled while stalled
        for (int lc = 1; lc < 8; lc++) begin
            cfg <= '{lc[2:0], lc[0], lc[1], 1'b1, 1'b0};
            wr_ready <= 1'b0;
            @(posedge clk);
            host.burst(1'b1, FIFO_DEPTH, wc);
            check("write wait edges", lc, wc);
            drain();
        end
        $display("write test done");
        for (int lc = 2; lc < 5; lc++) begin
            cfg <= '{lc[2:0], lc[0], lc[0], 1'b1, 1'b0};
            @(posedge clk);
            n_rd = 0;
            host.burst(1'b0, 4, wc);
            check("read wait edges", lc + 1, wc);
            check("read words", 4, n_rd);
        end
        $display("read test done");
        pd_enter <= 1'b1;
        repeat (4) @(posedge clk);
        pd_enter <= 1'b0;
        check("pd_active", 1, pd_active);
        host.pulse(100);
        for (int i = 0; i < PDX + 40 && ready !== 1'b1; i++) @(posedge clk);
        check("ready after exit", 1, ready);
        check("pd_active after exit", 0, pd_active);
        $display("power-down test done");
        finish_test();
    end
endmodule
